// ---- logic/game_query_responder.sv ----
// spi slave command responder: link-side shifter and core-side interpreter
`timescale 1ns/10ps
module game_query_responder #(
    parameter int BUF_DEPTH = query_responder_pkg::FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sck,
    input wire logic i_ss_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    input wire logic [3:0] i_frequency_code_field,
    input wire logic [2:0] i_color_code,
    input wire logic [15:0] i_north_score_field,
    input wire logic [15:0] i_south_score_field,
    input wire logic [7:0] i_game_status,
    input wire logic [7:0] i_item_value_byte,
    output logic o_registered,
    output logic o_registered_team,
    output logic o_registration_rejected,
    output logic [9:0] o_check_period_us
);
    initial begin
        if (BUF_DEPTH < 4) begin
            $error("game_query_responder: buffer must hold a full score payload");
        end
    end

    // byte of a packed response word, first byte in the top lane
    function automatic logic [7:0] word_byte(input logic [31:0] word, input logic [1:0] idx);
        case (idx)
            2'd0: word_byte = word[31:24];
            2'd1: word_byte = word[23:16];
            2'd2: word_byte = word[15:8];
            default: word_byte = word[7:0];
        endcase
    endfunction

    // ---------------- link domain, cleared while select is high ----------------
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [6:0] rx_shift;
    logic [7:0] cmd_byte;
    logic cmd_seen;
    logic [7:0] tx_shift;
    logic ready_meta;
    logic ready_link;

    // core-side response, held still while resp_ready is high
    logic [31:0] resp_word;
    logic [2:0] resp_len;
    logic resp_ready;

    wire [7:0] rx_byte = {rx_shift, i_mosi};
    wire byte_done = (bit_cnt == 3'd7);
    wire [2:0] tx_idx = byte_cnt - query_responder_pkg::POS_PAYLOAD;
    wire in_payload = ready_link && (byte_cnt >= query_responder_pkg::POS_PAYLOAD)
        && (tx_idx < resp_len);
    // past the payload, or with no response ready, the filler goes out
    wire [7:0] next_tx = in_payload ? word_byte(resp_word, tx_idx[1:0])
        : query_responder_pkg::BYTE_FILL;

    // ss_n is the frame's own signal, so it clears the frame state without sck edges
    always_ff @(posedge i_sck or posedge i_ss_n) begin
        if (i_ss_n) begin
            bit_cnt <= 3'd0;
            byte_cnt <= 3'd0;
            rx_shift <= 7'h00;
            cmd_byte <= 8'h00;
            cmd_seen <= 1'b0;
        end else begin
            rx_shift <= rx_byte[6:0];
            bit_cnt <= bit_cnt + 3'd1;
            if (byte_done) begin
                if (byte_cnt != query_responder_pkg::POS_LAST) begin
                    byte_cnt <= byte_cnt + 3'd1;
                end
                // only the first byte is a command; later bytes are padding
                if (byte_cnt == 3'd0) begin
                    cmd_byte <= rx_byte;
                    cmd_seen <= 1'b1;
                end
            end
        end
    end

    // mode 0: data changes on the falling edge, so the lead byte sits in reset
    always_ff @(negedge i_sck or posedge i_ss_n) begin
        if (i_ss_n) begin
            tx_shift <= query_responder_pkg::BYTE_LEAD;
            ready_meta <= 1'b0;
            ready_link <= 1'b0;
        end else begin
            ready_meta <= resp_ready;
            ready_link <= ready_meta;
            if (bit_cnt == 3'd0) begin
                tx_shift <= (byte_cnt == query_responder_pkg::POS_FILL)
                    ? query_responder_pkg::BYTE_FILL : next_tx;
            end else begin
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
    end

    assign o_miso = tx_shift[7];

    // ---------------- core domain ----------------
    logic seen_meta;
    logic seen_sync;
    logic seen_prev;
    logic ss_meta;
    logic ss_sync;
    query_responder_pkg::seq_state_t state;
    query_responder_pkg::seq_state_t next_state;
    logic [31:0] payload;
    logic [2:0] pay_len;
    logic [2:0] push_cnt;
    logic [2:0] pack_cnt;
    logic registered;
    logic reg_team;
    logic rejected;
    logic miso_oe;
    logic [9:0] period_us;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            seen_meta <= 1'b0;
            seen_sync <= 1'b0;
            seen_prev <= 1'b0;
            ss_meta <= 1'b1;
            ss_sync <= 1'b1;
        end else begin
            seen_meta <= cmd_seen;
            seen_sync <= seen_meta;
            seen_prev <= seen_sync;
            ss_meta <= i_ss_n;
            ss_sync <= ss_meta;
        end
    end

    wire cmd_rise = seen_sync && !seen_prev;

    // registration byte checks
    wire reg_zero_ok = (cmd_byte & query_responder_pkg::REG_ZERO_MASK) == 8'h00;
    wire reg_compl_ok = cmd_byte[query_responder_pkg::REG_COMPL_BIT]
        == !cmd_byte[query_responder_pkg::REG_TEAM_BIT];
    wire reg_legal = reg_zero_ok && reg_compl_ok;
    wire req_team = cmd_byte[query_responder_pkg::REG_TEAM_BIT];
    wire reg_success = !registered && reg_legal;

    // acknowledgement: ok bit only on the one successful registration
    wire ack_team = registered ? reg_team : req_team;
    wire [7:0] ack_byte = {query_responder_pkg::ACK_PATTERN, 2'b00,
        ack_team && (registered || reg_legal), reg_success};

    wire [7:0] team_byte = {i_frequency_code_field, i_color_code, reg_team};

    // decode of the command into a left-aligned payload and its length
    logic [31:0] dec_payload;
    logic [2:0] dec_len;
    always_comb begin
        dec_payload = query_responder_pkg::RST_WORD;
        dec_len = query_responder_pkg::LEN_NONE;
        if (!registered || reg_legal) begin
            // before registration every command is a registration attempt
            dec_payload = {ack_byte, 24'h000000};
            dec_len = query_responder_pkg::LEN_ONE;
        end else begin
            case (cmd_byte)
                query_responder_pkg::CMD_TEAM_INFO: begin
                    dec_payload = {team_byte, 24'h000000};
                    dec_len = query_responder_pkg::LEN_ONE;
                end
                query_responder_pkg::CMD_SCORES: begin
                    dec_payload = {i_north_score_field, i_south_score_field};
                    dec_len = query_responder_pkg::LEN_SCORES;
                end
                query_responder_pkg::CMD_STATUS: begin
                    dec_payload = {i_game_status, 24'h000000};
                    dec_len = query_responder_pkg::LEN_ONE;
                end
                query_responder_pkg::CMD_VALUE: begin
                    dec_payload = {i_item_value_byte, 24'h000000};
                    dec_len = query_responder_pkg::LEN_ONE;
                end
                default: begin
                    dec_payload = query_responder_pkg::RST_WORD;
                    dec_len = query_responder_pkg::LEN_NONE;
                end
            endcase
        end
    end

    // response buffer between the interpreter and the packer
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire fifo_in_valid = (state == query_responder_pkg::ST_PUSH) && (push_cnt != pay_len);
    wire fifo_out_ready = (state == query_responder_pkg::ST_PACK)
        || (state == query_responder_pkg::ST_DRAIN);
    wire do_push = fifo_in_valid && fifo_in_ready;
    wire do_pop = fifo_out_ready && fifo_out_valid;
    wire pack_write = do_pop && (state == query_responder_pkg::ST_PACK);

    response_fifo #(
        .WIDTH(query_responder_pkg::FIFO_WIDTH),
        .DEPTH(BUF_DEPTH)
    ) u_response_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(payload[31:24]),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data)
    );

    always_comb begin
        next_state = state;
        case (state)
            query_responder_pkg::ST_IDLE: begin
                if (cmd_rise) begin
                    next_state = query_responder_pkg::ST_PUSH;
                end
            end
            query_responder_pkg::ST_PUSH: begin
                if (ss_sync) begin
                    next_state = query_responder_pkg::ST_DRAIN;
                end else if (push_cnt == pay_len) begin
                    next_state = query_responder_pkg::ST_PACK;
                end
            end
            query_responder_pkg::ST_PACK: begin
                if (ss_sync) begin
                    next_state = query_responder_pkg::ST_DRAIN;
                end else if (pack_cnt == pay_len) begin
                    next_state = query_responder_pkg::ST_HOLD;
                end
            end
            query_responder_pkg::ST_HOLD: begin
                if (ss_sync) begin
                    next_state = query_responder_pkg::ST_IDLE;
                end
            end
            query_responder_pkg::ST_DRAIN: begin
                if (!fifo_out_valid) begin
                    next_state = query_responder_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = query_responder_pkg::ST_IDLE;
            end
        endcase
    end

    wire [31:0] pack_lane = {fifo_out_data, 24'h000000} >> {pack_cnt, 3'b000};
    wire frame_over = ss_sync || (state == query_responder_pkg::ST_IDLE);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= query_responder_pkg::ST_IDLE;
            payload <= query_responder_pkg::RST_WORD;
            pay_len <= query_responder_pkg::LEN_NONE;
            push_cnt <= 3'd0;
            pack_cnt <= 3'd0;
            resp_word <= query_responder_pkg::RST_WORD;
            resp_len <= query_responder_pkg::LEN_NONE;
            resp_ready <= 1'b0;
        end else begin
            state <= next_state;
            if (state == query_responder_pkg::ST_IDLE && cmd_rise) begin
                payload <= dec_payload;
                pay_len <= dec_len;
                push_cnt <= 3'd0;
                pack_cnt <= 3'd0;
                resp_word <= query_responder_pkg::RST_WORD;
            end
            if (do_push) begin
                payload <= {payload[23:0], 8'h00};
                push_cnt <= push_cnt + 3'd1;
            end
            if (pack_write) begin
                resp_word <= resp_word | pack_lane;
                pack_cnt <= pack_cnt + 3'd1;
            end
            // resp_word and resp_len stand still from here until select rises
            if (state == query_responder_pkg::ST_PACK && !ss_sync && pack_cnt == pay_len) begin
                resp_len <= pay_len;
                resp_ready <= 1'b1;
            end else if (frame_over) begin
                resp_ready <= 1'b0;
            end
        end
    end

    // registration is sticky until reset, so later attempts cannot change the team
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            registered <= query_responder_pkg::RST_REGISTERED;
            reg_team <= query_responder_pkg::RST_TEAM;
            rejected <= 1'b0;
        end else if (state == query_responder_pkg::ST_IDLE && cmd_rise) begin
            if (reg_success) begin
                registered <= 1'b1;
                reg_team <= req_team;
                rejected <= 1'b0;
            end else if (!registered) begin
                rejected <= 1'b1;
            end
        end
    end

    // enable lags select by the synchroniser, far inside the select-to-clock gap
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            miso_oe <= 1'b0;
            period_us <= query_responder_pkg::PERIOD_US[0];
        end else begin
            miso_oe <= !ss_sync;
            period_us <= query_responder_pkg::PERIOD_US[i_frequency_code_field];
        end
    end

    assign o_miso_oe = miso_oe;
    assign o_registered = registered;
    assign o_registered_team = reg_team;
    assign o_registration_rejected = rejected;
    assign o_check_period_us = period_us;

endmodule // game_query_responder

// ---- logic/query_responder_pkg.sv ----
// constants and types shared by the query responder and its buffer
package query_responder_pkg;

    // command bytes
    localparam logic [7:0] CMD_TEAM_INFO = 8'hD2;
    localparam logic [7:0] CMD_SCORES = 8'hB4;
    localparam logic [7:0] CMD_STATUS = 8'h78;
    localparam logic [7:0] CMD_VALUE = 8'h69;

    // fixed lead and filler bytes
    localparam logic [7:0] BYTE_LEAD = 8'h00;
    localparam logic [7:0] BYTE_FILL = 8'hFF;

    // registration byte layout
    localparam int REG_TEAM_BIT = 0;
    localparam int REG_COMPL_BIT = 4;
    localparam logic [7:0] REG_ZERO_MASK = 8'hEE;

    // acknowledgement byte layout
    localparam logic [3:0] ACK_PATTERN = 4'hA;
    localparam int ACK_TEAM_BIT = 1;
    localparam int ACK_OK_BIT = 0;

    // payload lengths in bytes
    localparam logic [2:0] LEN_NONE = 3'd0;
    localparam logic [2:0] LEN_ONE = 3'd1;
    localparam logic [2:0] LEN_SCORES = 3'd4;

    // transaction byte positions
    localparam logic [2:0] POS_FILL = 3'd1;
    localparam logic [2:0] POS_PAYLOAD = 3'd2;
    localparam logic [2:0] POS_LAST = 3'd7;

    // response buffer
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;

    // reset values
    localparam logic RST_REGISTERED = 1'b0;
    localparam logic RST_TEAM = 1'b0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // check-in period in microseconds, indexed by frequency code
    localparam logic [9:0] PERIOD_US [16] = '{
        10'd1000, 10'd947, 10'd893, 10'd840, 10'd787, 10'd733, 10'd680, 10'd627,
        10'd573, 10'd520, 10'd467, 10'd413, 10'd360, 10'd307, 10'd253, 10'd200
    };

    // core sequencer, gray coded along idle-push-pack-hold
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PUSH = 3'b001,
        ST_PACK = 3'b011,
        ST_HOLD = 3'b010,
        ST_DRAIN = 3'b110
    } seq_state_t;

endpackage

// ---- logic/response_fifo.sv ----
// synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module response_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("response_fifo: DEPTH must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;

    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire do_push = i_in_valid && !full;
    wire do_pop = i_out_ready && !empty;

    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem[wr_ptr[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

endmodule // response_fifo

// ---- dv/game_query_responder_sva.sv ----
// assertions on the query responder ports
`timescale 1ns/10ps
module game_query_responder_sva (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sck,
    input wire logic i_ss_n,
    input wire logic o_miso,
    input wire logic o_miso_oe,
    input wire logic [3:0] i_frequency_code_field,
    input wire logic o_registered,
    input wire logic o_registered_team,
    input wire logic o_registration_rejected,
    input wire logic [9:0] o_check_period_us
);
    logic [4:0] bit_cnt;

    // rises seen in the frame, cleared by select like the link logic
    always_ff @(posedge i_sck or posedge i_ss_n) begin
        if (i_ss_n) begin
            bit_cnt <= 5'h00;
        end else if (bit_cnt != 5'h1F) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    property p_lead_zero;
        @(posedge i_sck) disable iff (i_ss_n) bit_cnt < 5'h08 |-> !o_miso;
    endproperty
    a_lead_zero: assert property (p_lead_zero) else $error("miso not low in first byte");

    property p_fill_ones;
        @(posedge i_sck) disable iff (i_ss_n)
            bit_cnt >= 5'h08 && bit_cnt < 5'h10 |-> o_miso;
    endproperty
    a_fill_ones: assert property (p_fill_ones) else $error("second byte not all ones");

    property p_idle_low;
        @(posedge i_clk) disable iff (i_rst) i_ss_n |-> !o_miso;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("miso high while deselected");

    property p_oe_off;
        @(posedge i_clk) disable iff (i_rst) i_ss_n [*5] |-> !o_miso_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso driven while deselected");

    property p_oe_on;
        @(posedge i_clk) disable iff (i_rst) !i_ss_n [*5] |-> o_miso_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso not driven in frame");

    property p_period;
        @(posedge i_clk) disable iff (i_rst) !$past(i_rst) |->
            o_check_period_us == query_responder_pkg::PERIOD_US[$past(i_frequency_code_field)];
    endproperty
    a_period: assert property (p_period) else $error("period does not follow code");

    property p_reg_sticky;
        @(posedge i_clk) disable iff (i_rst) o_registered |=> o_registered;
    endproperty
    a_reg_sticky: assert property (p_reg_sticky) else $error("registration lost");

    property p_team_fixed;
        @(posedge i_clk) disable iff (i_rst) o_registered |=> $stable(o_registered_team);
    endproperty
    a_team_fixed: assert property (p_team_fixed) else $error("team changed");

    property p_ok_no_reject;
        @(posedge i_clk) disable iff (i_rst) o_registered |-> !o_registration_rejected;
    endproperty
    a_ok_no_reject: assert property (p_ok_no_reject) else $error("reject with success");

    property p_quiet_flags;
        @(posedge i_clk) disable iff (i_rst) i_ss_n [*8] |->
            $stable(o_registered) && $stable(o_registration_rejected);
    endproperty
    a_quiet_flags: assert property (p_quiet_flags) else $error("flags moved idle");

    c_registered: cover property (@(posedge i_clk) $rose(o_registered));
    c_rejected: cover property (@(posedge i_clk) $rose(o_registration_rejected));
    c_payload: cover property (@(posedge i_sck) bit_cnt == 5'h10);
endmodule // game_query_responder_sva

bind game_query_responder game_query_responder_sva game_query_responder_sva_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_sck(i_sck), .i_ss_n(i_ss_n), .o_miso(o_miso),
    .o_miso_oe(o_miso_oe), .i_frequency_code_field(i_frequency_code_field),
    .o_registered(o_registered), .o_registered_team(o_registered_team),
    .o_registration_rejected(o_registration_rejected), .o_check_period_us(o_check_period_us)
);

// ---- dv/spi_master_model.sv ----
// robot controller model: spi master, mode 0, msb first
`timescale 1ns/10ps
module spi_master_model (
    output logic o_sck,
    output logic o_ss_n,
    output logic o_mosi,
    input wire logic i_miso,
    output logic o_rx_valid,
    output logic [7:0] o_rx_byte
);
    initial begin
        o_sck = 1'b0;
        o_ss_n = 1'b0;
        o_mosi = 1'b0;
        o_rx_valid = 1'b0;
        o_rx_byte = 8'h00;
        // a clean rise of select clears the link logic, a time-zero edge may be missed
        #2 o_ss_n = 1'b1;
    end

    // gap between bytes lets the slow core build its answer
    task automatic frame(input logic [7:0] cmd, input int n, input int gap);
        logic [7:0] tx;
        logic [7:0] rx;
        o_ss_n = 1'b0;
        #60;
        for (int b = 0; b < n; b++) begin
            tx = (b == 0) ? cmd : 8'h00;
            for (int i = 7; i >= 0; i--) begin
                o_mosi = tx[i];
                #7.5 o_sck = 1'b1;
                rx[i] = i_miso;
                #7.5 o_sck = 1'b0;
            end
            o_rx_byte = rx;
            o_rx_valid = 1'b1;
            #1 o_rx_valid = 1'b0;
            #(gap);
        end
        o_ss_n = 1'b1;
        // released line shows a changed level, not the last bit
        o_mosi = ~o_mosi;
        #200;
    endtask
endmodule // spi_master_model

// ---- dv/game_query_responder_tb.sv ----
// self-checking bench for the query responder and its buffer
`timescale 1ns/10ps
module game_query_responder_tb;
    logic i_clk, i_rst, sck, ss_n, mosi, miso, miso_oe, miso_line, rx_valid;
    logic registered, team, rejected;
    logic [7:0] rx_byte, status, value;
    logic [3:0] frequency_code_field;
    logic [2:0] color;
    logic [15:0] north, south;
    logic [9:0] period;
    logic [7:0] exp_q [$];
    logic [31:0] seed = 32'h0000_0055;
    int fail_count, checks_done;

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // undriven line shows the opposite level so a missing enable shows up
    assign miso_line = miso_oe ? miso : ~miso;

    game_query_responder #(.BUF_DEPTH(16)) game_query_responder_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_sck(sck), .i_ss_n(ss_n), .i_mosi(mosi),
        .o_miso(miso), .o_miso_oe(miso_oe), .i_frequency_code_field(frequency_code_field),
        .i_color_code(color), .i_north_score_field(north), .i_south_score_field(south),
        .i_game_status(status), .i_item_value_byte(value), .o_registered(registered),
        .o_registered_team(team), .o_registration_rejected(rejected),
        .o_check_period_us(period));
    spi_master_model spi_master_model_i (.o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi),
        .i_miso(miso_line), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // notes the expected bytes, oldest first, then runs the frame
    task automatic frame(input logic [7:0] cmd, input int n, input logic [47:0] exp);
        for (int k = n - 1; k >= 0; k--) begin
            exp_q.push_back(exp[8*k+:8]);
        end
        spi_master_model_i.frame(cmd, n, 150 + int'(rnd() % 300));
        chk("bytes missing", 16'h0000, 16'(exp_q.size()));
    endtask

    task automatic set_data();
        logic [31:0] r;
        r = rnd();
        @(posedge i_clk);
        frequency_code_field <= r[3:0];
        color <= 3'(r[6:4] % 6);
        status <= r[15:8];
        value <= r[23:16];
        r = rnd();
        north <= r[15:0];
        south <= r[31:16];
        repeat (2) @(posedge i_clk);
    endtask

    initial begin
        logic [7:0] e;
        forever begin
            @(posedge rx_valid);
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hXX;
            chk("miso byte", {8'h00, e}, {8'h00, rx_byte});
        end
    end

    initial begin
        repeat (60000) @(posedge i_clk);
        fail_count++;
        $display("unexpected run: expected end seen timeout");
        finish_test();
    end

    initial begin
        i_rst = 1'b1;
        frequency_code_field = 4'h0;
        color = 3'h0;
        north = 16'h0000;
        south = 16'h0000;
        status = 8'h00;
        value = 8'h00;
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk("registered", 16'h0000, {15'h0000, registered});
        frame(query_responder_pkg::CMD_STATUS, 4, 48'h00FFA0FF);
        chk("rejected", 16'h0001, {15'h0000, rejected});
        frame(8'h11, 3, 48'h00FFA0);
        frame(8'h01, 3, 48'h00FFA3);
        chk("registered", 16'h0001, {15'h0000, registered});
        chk("rejected", 16'h0000, {15'h0000, rejected});
        frame(8'h10, 3, 48'h00FFA2);
        chk("team", 16'h0001, {15'h0000, team});
        repeat (6) begin
            set_data();
            frame(query_responder_pkg::CMD_TEAM_INFO, 3, {16'h00FF, frequency_code_field, color, 1'b1});
            frame(query_responder_pkg::CMD_SCORES, 6, {16'h00FF, north, south});
            frame(query_responder_pkg::CMD_STATUS, 3, {16'h00FF, status});
            frame(query_responder_pkg::CMD_VALUE, 3, {16'h00FF, value});
            frame(8'h5A, 4, 48'h00FFFFFF);
            frame(query_responder_pkg::CMD_TEAM_INFO, 1, 48'h00);
        end
        // second power-up: flags back to reset values, then one new registration
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk("registered", 16'h0000, {15'h0000, registered});
        chk("team", 16'h0000, {15'h0000, team});
        chk("rejected", 16'h0000, {15'h0000, rejected});
        chk("period", 16'h03E8, {6'h00, period});
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        frame(8'h10, 3, 48'h00FFA1);
        chk("registered", 16'h0001, {15'h0000, registered});
        chk("team", 16'h0000, {15'h0000, team});
        frame(query_responder_pkg::CMD_TEAM_INFO, 3, {16'h00FF, frequency_code_field, color, 1'b0});
        frame(query_responder_pkg::CMD_SCORES, 6, {16'h00FF, north, south});
        for (int c = 0; c < 16; c++) begin
            @(posedge i_clk);
            frequency_code_field <= 4'(c);
            repeat (2) @(posedge i_clk);
            chk("period", 16'((15000 - c * 800 + 7) / 15), {6'h00, period});
        end
        finish_test();
    end
endmodule // game_query_responder_tb
